// file: adcdc_meas.sv
// DC measurement of the mono ADC stream with byte register access
`timescale 1ns/1ps
module adcdc_meas
   import adcdc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic mod_strobe,
   input wire logic signed [ADCDC_SAMP_W-1:0] mod_sample,
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_r
);
   adcdc_ctrl1_t ctrl1_r;
   adcdc_ctrl2_t ctrl2_r;
   logic [ADCDC_RES_W-1:0] result_r;
   logic signed [ADCDC_ACC_W-1:0] acc_r;
   logic signed [ADCDC_ACC_W-1:0] acc_nxt;
   logic [ADCDC_CNT_W:0] scnt_r;
   logic [ADCDC_CNT_W:0] sinc_last;
   logic signed [ADCDC_RES_W-1:0] iir_y_r;
   logic signed [ADCDC_RES_W-1:0] iir_nxt;
   logic signed [ADCDC_RES_W:0] iir_diff;
   logic [ADCDC_CNT_W:0] pcnt_r;
   logic [ADCDC_CNT_W:0] per_last;
   logic iir_clr;
   logic new_vld;
   logic [ADCDC_RES_W-1:0] new_val;
   logic run;

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ctrl1_r <= ADCDC_CTRL1_RST;
         ctrl2_r <= ADCDC_CTRL2_RST;
      end else if (reg_wr) begin
         // Reserved bits are dropped; they always read back as zero
         if (reg_addr == ADCDC_OFF_CTRL1) begin
            ctrl1_r <= '{reg_wdata[7], reg_wdata[5], reg_wdata[4:0]};
         end
         if (reg_addr == ADCDC_OFF_CTRL2) begin
            ctrl2_r <= '{reg_wdata[6], reg_wdata[5], reg_wdata[4:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Filters
   assign run = ctrl1_r.enable && mod_strobe;

   // Reserved D codes are clamped so a bad value cannot overrun the counters
   always_comb begin
      logic [4:0] d;
      logic [4:0] n;
      d = (ctrl1_r.d_set > ADCDC_CODE_MAX) ? ADCDC_CODE_MAX : ctrl1_r.d_set;
      n = (ctrl2_r.avg_code > ADCDC_CODE_MAX) ? ADCDC_CODE_MAX
                                              : ctrl2_r.avg_code;
      sinc_last = (21'h00_0001 << d) - 21'h00_0001;
      per_last = (21'h00_0001 << n) - 21'h00_0001;
      acc_nxt = acc_r + ADCDC_ACC_W'(mod_sample);
      // A concatenation is unsigned, so recast it or negative samples
      // would zero-extend and pull the filter the wrong way
      iir_diff = (ADCDC_RES_W+1)'(signed'({mod_sample, 8'h00}))
                 - (ADCDC_RES_W+1)'(iir_y_r);
      iir_nxt = iir_y_r + ADCDC_RES_W'(iir_diff >>> d);
   end

   // The clear exists for every nonzero code, codes above 20 acting as 20; code zero free-runs
   assign iir_clr = run && ctrl1_r.filt_iir && (ctrl2_r.avg_code != 5'h00)
                    && (pcnt_r == per_last);

   always_ff @(posedge sys_clk) begin
      if (!reset_n || !ctrl1_r.enable || ctrl1_r.filt_iir) begin
         acc_r <= '0;
         scnt_r <= '0;
      end else if (mod_strobe) begin
         if (scnt_r >= sinc_last) begin
            acc_r <= '0;
            scnt_r <= '0;
         end else begin
            acc_r <= acc_nxt;
            scnt_r <= scnt_r + 21'h00_0001;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n || !ctrl1_r.enable || !ctrl1_r.filt_iir) begin
         iir_y_r <= '0;
         pcnt_r <= '0;
      end else if (mod_strobe) begin
         if (iir_clr) begin
            iir_y_r <= '0;
            pcnt_r <= '0;
         end else begin
            iir_y_r <= iir_nxt;
            pcnt_r <= (ctrl2_r.avg_code == 5'h00) ? '0 : pcnt_r + 21'h00_0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result selection and hold
   always_comb begin
      logic signed [ADCDC_ACC_W-1:0] avg;
      avg = acc_nxt >>> ctrl1_r.d_set;
      new_vld = 1'b0;
      new_val = iir_nxt;
      if (run && !ctrl1_r.filt_iir) begin
         new_vld = (scnt_r >= sinc_last);
         new_val = ADCDC_RES_W'(avg);
      end else if (run) begin
         new_vld = !ctrl2_r.latch || iir_clr;
      end
   end

   // Whole word is loaded at once; the hold bit, or a cleared enable bit, stops the three byte reads from mixing passes
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         result_r <= ADCDC_RES_RST;
      end else if (new_vld && !ctrl2_r.hold) begin
         result_r <= new_val;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register reads, one cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         reg_rdata_r <= ADCDC_BYTE_RST;
      end else if (reg_rd) begin
         case (reg_addr)
            ADCDC_OFF_CTRL1: reg_rdata_r <= {ctrl1_r.enable, 1'b0,
                                             ctrl1_r.filt_iir, ctrl1_r.d_set};
            ADCDC_OFF_CTRL2: reg_rdata_r <= {1'b0, ctrl2_r};
            ADCDC_OFF_RES_H: reg_rdata_r <= result_r[23:16];
            ADCDC_OFF_RES_M: reg_rdata_r <= result_r[15:8];
            ADCDC_OFF_RES_L: reg_rdata_r <= result_r[7:0];
            default: reg_rdata_r <= ADCDC_BYTE_RST;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_disabled_still;
      @(posedge sys_clk) disable iff (!reset_n)
      !ctrl1_r.enable |=> result_r == $past(result_r);
   endproperty
   a_disabled_still: assert property (p_disabled_still)
      else $error("result moved while measurement disabled");

   property p_hold_still;
      @(posedge sys_clk) disable iff (!reset_n)
      ctrl2_r.hold |=> $stable(result_r);
   endproperty
   a_hold_still: assert property (p_hold_still)
      else $error("result moved while update hold set");

   sequence s_sinc_done;
      ctrl1_r.enable && !ctrl1_r.filt_iir && mod_strobe
      && scnt_r == sinc_last && !ctrl2_r.hold;
   endsequence
   property p_sinc_load;
      @(posedge sys_clk) disable iff (!reset_n)
      s_sinc_done |=> result_r == $past(new_val) && scnt_r == 21'h00_0000;
   endproperty
   a_sinc_load: assert property (p_sinc_load)
      else $error("sinc average not loaded at end of block");

   property p_iir_live;
      @(posedge sys_clk) disable iff (!reset_n)
      run && ctrl1_r.filt_iir && !ctrl2_r.latch && !ctrl2_r.hold
      |=> result_r == $past(iir_nxt);
   endproperty
   a_iir_live: assert property (p_iir_live)
      else $error("live IIR output not reported");

   property p_latch_wait;
      @(posedge sys_clk) disable iff (!reset_n)
      ctrl1_r.filt_iir && ctrl2_r.latch && !iir_clr |=> $stable(result_r);
   endproperty
   a_latch_wait: assert property (p_latch_wait)
      else $error("latched result changed away from a clear");

   property p_infinite;
      @(posedge sys_clk) disable iff (!reset_n)
      ctrl1_r.enable && ctrl1_r.filt_iir && mod_strobe
      && ctrl2_r.avg_code == 5'h00 |=> iir_y_r == $past(iir_nxt);
   endproperty
   a_infinite: assert property (p_infinite)
      else $error("IIR cleared with infinite averaging");

   sequence s_clear;
      iir_clr;
   endsequence
   property p_clear_period;
      @(posedge sys_clk) disable iff (!reset_n)
      s_clear |-> pcnt_r == per_last ##1 (iir_y_r == 24'h00_0000
                                         && pcnt_r == 21'h00_0000);
   endproperty
   a_clear_period: assert property (p_clear_period)
      else $error("IIR clear off period or filter not zeroed");

   property p_byte_high;
      @(posedge sys_clk) disable iff (!reset_n)
      reg_rd && reg_addr == ADCDC_OFF_RES_H
      |=> reg_rdata_r == $past(result_r[23:16]);
   endproperty
   a_byte_high: assert property (p_byte_high)
      else $error("high result byte read wrong");

   property p_reset_zero;
      @(posedge sys_clk) !reset_n |=> result_r == 24'h00_0000;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("result not zero after reset");

   property p_word_load;
      @(posedge sys_clk) disable iff (!reset_n)
      new_vld && !ctrl2_r.hold |=> result_r == $past(new_val);
   endproperty
   a_word_load: assert property (p_word_load)
      else $error("result word not loaded whole");
endmodule : adcdc_meas

// file: adcdc_pkg.sv
// Constants, register map and carrier types for the ADC DC measurement block
// How it works
// - Measure DC on the mono ADC only while the enable bit is set.
// - Filter select: 0 averages 2^D samples by sinc, 1 uses IIR from D.
// - Update-hold bit set stops result updates so reads stay intact.
// - IIR latch bit 0 reports live output; 1 reports value before clear.
// - Averaging-time code zero never clears the IIR filter.
// - Codes 1 to 20 clear the IIR filter every 2^N modulator periods.
// - Result bytes: 23:16 first, 15:8 second, 7:0 third register.
// - All three result bytes read zero after reset.
package adcdc_pkg;
   localparam logic [6:0] ADCDC_OFF_CTRL1 = 7'h66;
   localparam logic [6:0] ADCDC_OFF_CTRL2 = 7'h67;
   localparam logic [6:0] ADCDC_OFF_RES_H = 7'h68;
   localparam logic [6:0] ADCDC_OFF_RES_M = 7'h69;
   localparam logic [6:0] ADCDC_OFF_RES_L = 7'h6a;
   localparam logic [6:0] ADCDC_OFF_RSVD_FIRST = 7'h6b;
   localparam logic [6:0] ADCDC_OFF_RSVD_LAST = 7'h73;
   localparam int ADCDC_RES_W = 24;
   localparam int ADCDC_SAMP_W = 16;
   localparam int ADCDC_ACC_W = 37;
   localparam int ADCDC_CNT_W = 20;
   localparam logic [4:0] ADCDC_CODE_MAX = 5'h14;
   localparam logic [23:0] ADCDC_RES_RST = 24'h00_0000;
   localparam logic [7:0] ADCDC_BYTE_RST = 8'h00;
   localparam int ADCDC_IIR_SCALE = 8;

   typedef struct packed {
      logic enable;
      logic filt_iir;
      logic [4:0] d_set;
   } adcdc_ctrl1_t;

   typedef struct packed {
      logic hold;
      logic latch;
      logic [4:0] avg_code;
   } adcdc_ctrl2_t;

   localparam adcdc_ctrl1_t ADCDC_CTRL1_RST = '{1'b0, 1'b0, 5'h00};
   localparam adcdc_ctrl2_t ADCDC_CTRL2_RST = '{1'b0, 1'b0, 5'h00};
endpackage : adcdc_pkg

// file: testbench.sv
// Self-checking testbench for the ADC DC measurement block
`timescale 1ns/1ps
module testbench;
   import adcdc_pkg::*;
   logic sys_clk;
   logic reset_n;
   logic mod_strobe;
   logic signed [ADCDC_SAMP_W-1:0] mod_sample;
   logic [6:0] reg_addr;
   logic reg_wr;
   logic [7:0] reg_wdata;
   logic reg_rd;
   logic [7:0] reg_rdata_r;
   logic rd_seen;
   logic [7:0] exp_q[$];
   logic [6:0] adr_q[$];
   logic [31:0] seed;
   logic signed [23:0] res;
   logic signed [23:0] y;
   logic signed [15:0] x;
   int miscompares;
   int checked;

   adcdc_meas i_adcdc_meas (.sys_clk(sys_clk), .reset_n(reset_n),
      .mod_strobe(mod_strobe), .mod_sample(mod_sample),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r));

   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   //////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish

   task automatic check(input logic [6:0] a, input logic [7:0] seen,
                        input logic [7:0] e);
      checked++;
      if (seen !== e) begin
         miscompares++;
         $display("wrong value reg_rdata_r at %h: expected %h seen %h",
                  a, e, seen);
      end
   endtask : check

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Expected byte is queued at the request; the monitor pairs it in order
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      adr_q.push_back(a);
      @(posedge sys_clk);
      reg_rd <= 1'b0;
   endtask : rd

   task automatic rd3(input logic [23:0] r);
      rd(7'h68, r[23:16]);
      rd(7'h69, r[15:8]);
      rd(7'h6a, r[7:0]);
   endtask : rd3

   task automatic smp(input logic signed [15:0] v);
      @(posedge sys_clk);
      mod_strobe <= 1'b1;
      mod_sample <= v;
      @(posedge sys_clk);
      mod_strobe <= 1'b0;
      mod_sample <= ~v;
   endtask : smp

   function automatic void get_x(output logic signed [15:0] v);
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      v = seed[15:0];
   endfunction : get_x

   // Wide intermediate avoids overflow of the 24-bit difference
   function automatic logic signed [23:0] iir(input logic signed [23:0] yo,
                                              input logic signed [15:0] v);
      int d;
      d = int'(v) * 256 - int'(yo);
      return yo + 24'(d >>> 1);
   endfunction : iir
   //////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk) begin
      if (rd_seen === 1'b1) check(adr_q.pop_front(), reg_rdata_r,
                                  exp_q.pop_front());
      rd_seen <= reg_rd;
   end

   initial begin
      repeat (5000) @(posedge sys_clk);
      miscompares++;
      tally_and_finish;
   end

   initial begin
      reset_n = 1'b0;
      mod_strobe = 1'b0;
      mod_sample = 16'sh0000;
      reg_addr = 7'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
      seed = 32'h324d;
      miscompares = 0;
      checked = 0;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      rd(7'h66, 8'h00);
      rd(7'h67, 8'h00);
      rd3(24'h000000);
      $display("test reset_values done");
      wr(7'h66, 8'h41);
      rd(7'h66, 8'h01);
      wr(7'h67, 8'h74);
      rd(7'h67, 8'h74);
      rd(7'h6b, 8'h00);
      wr(7'h68, 8'hff);
      rd(7'h68, 8'h00);
      $display("test register_access done");
      wr(7'h67, 8'h00);
      wr(7'h66, 8'h81);
      get_x(x);
      res = 24'(int'(x));
      smp(x);
      rd3(24'h000000);
      get_x(x);
      smp(x);
      res = 24'((int'(res) + int'(x)) >>> 1);
      rd3(res);
      $display("test sinc_average done");
      wr(7'h67, 8'h40);
      for (int i = 0; i < 2; i++) begin
         get_x(x);
         smp(x);
      end
      rd3(res);
      wr(7'h67, 8'h00);
      wr(7'h66, 8'h00);
      for (int i = 0; i < 2; i++) begin
         get_x(x);
         smp(x);
      end
      rd3(res);
      $display("test hold_and_disable done");
      wr(7'h66, 8'ha1);
      y = 24'sh000000;
      for (int i = 0; i < 3; i++) begin
         get_x(x);
         smp(x);
         y = iir(y, x);
         rd3(y);
      end
      $display("test iir_live done");
      wr(7'h66, 8'h00);
      wr(7'h67, 8'h21);
      wr(7'h66, 8'ha1);
      res = y;
      y = 24'sh000000;
      for (int i = 0; i < 4; i++) begin
         get_x(x);
         smp(x);
         y = iir(y, x);
         if (i % 2 == 1) begin
            res = y;
            y = 24'sh000000;
         end
         rd3(res);
      end
      $display("test iir_latched_clear done");
      repeat (4) @(posedge sys_clk);
      tally_and_finish;
   end
endmodule : testbench
